/* hw/tws_regs.svh */
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH
`define TWS_OFF_ADDR 8'h00
`define TWS_OFF_CTRL 8'h04
`define TWS_OFF_STAT 8'h08
`define TWS_OFF_DATA 8'h0c
`define TWS_OFF_SLEEP 8'h10
`define TWS_B_INT 7
`define TWS_B_ACK 6
`define TWS_B_STA 5
`define TWS_B_STO 4
`define TWS_B_WC 3
`define TWS_B_EN 2
`define TWS_B_IE 0
`define TWS_B_GCE 0
`define TWS_RST_ADDR 8'h00
`define TWS_RST_CTRL 8'h00
`define TWS_RST_DATA 8'hff
`define TWS_ST_NONE 8'hf8
`define TWS_ST_SLA_W 8'h60
`define TWS_ST_ARB_SLA_W 8'h68
`define TWS_ST_GC 8'h70
`define TWS_ST_ARB_GC 8'h78
`define TWS_ST_RX_ACK 8'h80
`define TWS_ST_RX_NACK 8'h88
`define TWS_ST_GC_ACK 8'h90
`define TWS_ST_GC_NACK 8'h98
`define TWS_ST_STOP 8'ha0
`define TWS_ST_SLA_R 8'ha8
`define TWS_ST_ARB_SLA_R 8'hb0
`define TWS_ST_TX_ACK 8'hb8
`define TWS_ST_TX_NACK 8'hc0
`define TWS_ST_TX_LAST 8'hc8
`define TWS_GC_ADDR 7'h00
`define TWS_BYTE_BITS 4'h8
`define TWS_ACK_BIT 4'h9
`endif

/* hw/tws_pkg.sv */
package tws_pkg;
   typedef enum logic [2:0] {
      TWS_IDLE,
      TWS_ADDR,
      TWS_RX,
      TWS_TX,
      TWS_WAIT,
      TWS_IGNORE
   } tws_state_t;
   typedef enum logic [1:0] {
      TWS_PH_RX,
      TWS_PH_TX
   } tws_phase_t;
endpackage

/* hw/tws_slave.sv */
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "tws_regs.svh"
// How it works
// - General-call byte acked: status 0x90, next byte acked per ack_enable.
// - General-call byte nacked: status 0x98, then not addressed.
// - start_req written with the flag clear after 0x88, 0x98, 0xA0, 0xC0 or 0xC8 queues a START once the bus is free.
// - STOP or repeated START while addressed: status 0xA0, then not addressed.
// - Respond to the seven-bit address in own_addr_reg upper bits.
// - gen_call_enable set answers general call 0x00, clear ignores it.
// - After address match, direction bit 1 selects transmit, else receive.
// - Acked own address sets int_flag and a valid status code.
// - Arbitration lost then addressed for read gives status 0xB0.
// - ack_enable 0 sends last byte; status 0xC0 on NACK, 0xC8 on ACK.
// - After the last byte ignore the master and keep SDA released.
// - ack_enable 0 stops address answers, bus still monitored.
// - In sleep, match and ack address, then request wake-up.
// - SCL is held low during wake-up until int_flag is cleared.
// - Received bytes are not stored in the data register while asleep; software writes still land.
// - Status codes assume prescaler bits zero; software masks them.
// - Own-address data byte nacked: status 0x88, then not addressed.
// - Own address with read: status 0xA8, software loads data first.
module tws_slave
   import tws_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic arb_lost,
   input wire logic sleep_active,
   output logic wake_req,
   output logic start_go
);
   tws_state_t state_ff;
   tws_phase_t phase_ff;
   logic scl1_ff, scl2_ff, scl3_ff, sda1_ff, sda2_ff, sda3_ff;
   logic [7:0] addr_ff, ctrl_ff, stat_ff, data_ff, sr_ff, tx_ff, ardata;
   logic [3:0] cnt_ff;
   logic ack_drv_ff, ack_this_ff, last_ff, gc_ff, arb_ff, mack_ff, busy_ff, int_ff;
   logic end_ff, pend_ff, aw_ff, w_ff, bvalid_ff, rvalid_ff;
   logic [7:0] aw_addr_ff, w_data_ff, nxt_code;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   logic rise, fall, start_det, stop_det, en, wr_en, sw_clr, hw_set, hw_end;
   logic match_own, match_gc, match, addressed;

   // Edges only from the second and third stages
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         {scl1_ff, scl2_ff, scl3_ff} <= 3'h7;
         {sda1_ff, sda2_ff, sda3_ff} <= 3'h7;
      end else begin
         {scl1_ff, scl2_ff, scl3_ff} <= {scl_i, scl1_ff, scl2_ff};
         {sda1_ff, sda2_ff, sda3_ff} <= {sda_i, sda1_ff, sda2_ff};
      end
   end
   assign rise = scl2_ff && !scl3_ff;
   assign fall = !scl2_ff && scl3_ff;
   assign start_det = scl2_ff && scl3_ff && sda3_ff && !sda2_ff;
   assign stop_det = scl2_ff && scl3_ff && !sda3_ff && sda2_ff;
   assign en = ctrl_ff[`TWS_B_EN];
   assign addressed = state_ff inside {TWS_RX, TWS_TX, TWS_WAIT};
   assign match_own = sr_ff[7:1] == addr_ff[7:1];
   assign match_gc = sr_ff[7:1] == `TWS_GC_ADDR && !sr_ff[0] && addr_ff[`TWS_B_GCE];
   assign match = (match_own || match_gc) && ctrl_ff[`TWS_B_ACK];

   // AXI4-Lite: address and data taken in either order
   assign s_axi_awready = !aw_ff && !bvalid_ff;
   assign s_axi_wready = !w_ff && !bvalid_ff;
   assign wr_en = aw_ff && w_ff && !bvalid_ff;
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign sw_clr = wr_en && aw_addr_ff == `TWS_OFF_CTRL && w_data_ff[`TWS_B_INT];

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         aw_addr_ff <= 8'h00;
         w_data_ff <= 8'h00;
         bresp_ff <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ff <= 1'b1;
            // Only the low lane carries register bits
            w_data_ff <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
         end
         if (wr_en) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= (aw_addr_ff > `TWS_OFF_SLEEP || aw_addr_ff[1:0] != 2'h0) ? 2'h2 : 2'h0;
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   always_comb begin
      unique case (s_axi_araddr)
         `TWS_OFF_ADDR: ardata = addr_ff;
         `TWS_OFF_CTRL: ardata = {int_ff, ctrl_ff[6:0]};
         `TWS_OFF_STAT: ardata = int_ff ? stat_ff : `TWS_ST_NONE;
         `TWS_OFF_DATA: ardata = data_ff;
         `TWS_OFF_SLEEP: ardata = {6'h00, pend_ff, wake_req};
         default: ardata = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= {24'h00_0000, ardata};
         rresp_ff <= (s_axi_araddr > `TWS_OFF_SLEEP || s_axi_araddr[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         addr_ff <= `TWS_RST_ADDR;
         ctrl_ff <= `TWS_RST_CTRL;
      end else if (wr_en && aw_addr_ff == `TWS_OFF_ADDR) begin
         addr_ff <= w_data_ff;
      end else if (wr_en && aw_addr_ff == `TWS_OFF_CTRL) begin
         ctrl_ff <= {1'b0, w_data_ff[6:4], ctrl_ff[`TWS_B_WC], w_data_ff[2:0]};
      end else if (wr_en && aw_addr_ff == `TWS_OFF_DATA && int_ff == 1'b0) begin
         ctrl_ff[`TWS_B_WC] <= 1'b1;
      end
   end

   // Status events from the serial side
   always_comb begin
      hw_set = 1'b0;
      hw_end = 1'b0;
      nxt_code = `TWS_ST_NONE;
      if ((start_det || stop_det) && addressed) begin
         hw_set = 1'b1;
         hw_end = 1'b1;
         nxt_code = `TWS_ST_STOP;
      end else if (fall && cnt_ff == `TWS_ACK_BIT) begin
         hw_set = 1'b1;
         unique case (state_ff)
            TWS_ADDR: begin
               if (sr_ff[0]) begin
                  nxt_code = arb_ff ? `TWS_ST_ARB_SLA_R : `TWS_ST_SLA_R;
               end else if (match_gc) begin
                  nxt_code = arb_ff ? `TWS_ST_ARB_GC : `TWS_ST_GC;
               end else begin
                  nxt_code = arb_ff ? `TWS_ST_ARB_SLA_W : `TWS_ST_SLA_W;
               end
            end
            TWS_RX: begin
               hw_end = !ack_this_ff;
               if (gc_ff) begin
                  nxt_code = ack_this_ff ? `TWS_ST_GC_ACK : `TWS_ST_GC_NACK;
               end else begin
                  nxt_code = ack_this_ff ? `TWS_ST_RX_ACK : `TWS_ST_RX_NACK;
               end
            end
            TWS_TX: begin
               hw_end = mack_ff || last_ff;
               if (mack_ff) begin
                  nxt_code = `TWS_ST_TX_NACK;
               end else begin
                  nxt_code = last_ff ? `TWS_ST_TX_LAST : `TWS_ST_TX_ACK;
               end
            end
            default: hw_set = 1'b0;
         endcase
      end
   end

   // A set in the clearing cycle wins
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         int_ff <= 1'b0;
         stat_ff <= `TWS_ST_NONE;
         end_ff <= 1'b0;
      end else if (hw_set) begin
         int_ff <= 1'b1;
         stat_ff <= nxt_code;
         end_ff <= hw_end;
      end else if (sw_clr) begin
         int_ff <= 1'b0;
      end
   end

   // Queued START waits for a free bus
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pend_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else begin
         if (start_det) begin
            busy_ff <= 1'b1;
         end else if (stop_det) begin
            busy_ff <= 1'b0;
         end
         if (sw_clr && int_ff && end_ff && w_data_ff[`TWS_B_STA] && !w_data_ff[`TWS_B_STO]) begin
            pend_ff <= 1'b1;
         end else if (start_go) begin
            pend_ff <= 1'b0;
         end
      end
   end
   assign start_go = pend_ff && !busy_ff && en;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         data_ff <= `TWS_RST_DATA;
      end else if (wr_en && aw_addr_ff == `TWS_OFF_DATA && int_ff) begin
         data_ff <= w_data_ff;
      end else if (state_ff == TWS_RX && fall && cnt_ff == `TWS_ACK_BIT && !sleep_active) begin
         data_ff <= sr_ff;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         arb_ff <= 1'b0;
      end else if (arb_lost) begin
         arb_ff <= 1'b1;
      end else if (stop_det || (state_ff == TWS_ADDR && fall && cnt_ff == `TWS_ACK_BIT)) begin
         arb_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset || !en) begin
         state_ff <= TWS_IDLE;
         phase_ff <= TWS_PH_RX;
         cnt_ff <= 4'h0;
         sr_ff <= 8'h00;
         tx_ff <= 8'hff;
         ack_drv_ff <= 1'b0;
         ack_this_ff <= 1'b0;
         last_ff <= 1'b0;
         gc_ff <= 1'b0;
         mack_ff <= 1'b1;
      end else if (stop_det) begin
         state_ff <= TWS_IDLE;
         ack_drv_ff <= 1'b0;
      end else if (start_det) begin
         state_ff <= TWS_ADDR;
         cnt_ff <= 4'h0;
         ack_drv_ff <= 1'b0;
      end else if (state_ff == TWS_WAIT) begin
         if (sw_clr) begin
            state_ff <= phase_ff == TWS_PH_TX ? TWS_TX : TWS_RX;
            ack_this_ff <= w_data_ff[`TWS_B_ACK];
            last_ff <= !w_data_ff[`TWS_B_ACK];
            tx_ff <= data_ff;
         end
      end else if (state_ff inside {TWS_ADDR, TWS_RX, TWS_TX}) begin
         if (rise && cnt_ff < `TWS_BYTE_BITS) begin
            sr_ff <= {sr_ff[6:0], sda2_ff};
            cnt_ff <= cnt_ff + 4'h1;
         end else if (rise && cnt_ff == `TWS_BYTE_BITS) begin
            mack_ff <= sda2_ff;
            cnt_ff <= `TWS_ACK_BIT;
         end else if (fall && cnt_ff != 4'h0 && cnt_ff < `TWS_BYTE_BITS) begin
            tx_ff <= {tx_ff[6:0], 1'b1};
         end else if (fall && cnt_ff == `TWS_BYTE_BITS) begin
            if (state_ff == TWS_ADDR && !match) begin
               state_ff <= TWS_IGNORE;
            end
            ack_drv_ff <= (state_ff == TWS_ADDR && match) || (state_ff == TWS_RX && ack_this_ff);
         end else if (fall && cnt_ff == `TWS_ACK_BIT) begin
            ack_drv_ff <= 1'b0;
            cnt_ff <= 4'h0;
            if (state_ff == TWS_ADDR) begin
               gc_ff <= !match_own;
               phase_ff <= sr_ff[0] ? TWS_PH_TX : TWS_PH_RX;
               state_ff <= TWS_WAIT;
            end else begin
               state_ff <= hw_end ? TWS_IGNORE : TWS_WAIT;
            end
         end
      end
   end

   // Open-drain lines only ever pull low
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe = state_ff == TWS_WAIT && int_ff;
   assign sda_oe = ack_drv_ff || (state_ff == TWS_TX && cnt_ff < `TWS_BYTE_BITS && !tx_ff[7]);
   assign wake_req = sleep_active && int_ff && state_ff == TWS_WAIT;

   stall_low_a: assert property (@(posedge ref_clk) disable iff (reset)
      (addressed && int_ff) |-> scl_oe)
      else $error("scl not held while flag set");
   stop_status_a: assert property (@(posedge ref_clk) disable iff (reset)
      (stop_det && addressed && en) |=> (int_ff && stat_ff == `TWS_ST_STOP && state_ff == TWS_IDLE))
      else $error("stop while addressed not reported");
   clear_resume_a: assert property (@(posedge ref_clk) disable iff (reset)
      (state_ff == TWS_WAIT && sw_clr && !hw_set && en && !start_det && !stop_det)
      |=> (!int_ff && state_ff inside {TWS_RX, TWS_TX}))
      else $error("resume after clear failed");
   no_ack_a: assert property (@(posedge ref_clk) disable iff (reset)
      (state_ff == TWS_ADDR && fall && cnt_ff == `TWS_BYTE_BITS && !ctrl_ff[`TWS_B_ACK] && en)
      |=> (state_ff == TWS_IGNORE && !ack_drv_ff))
      else $error("address answered with ack disabled");
   ignore_rel_a: assert property (@(posedge ref_clk) disable iff (reset)
      (state_ff == TWS_IGNORE) |-> !sda_oe)
      else $error("sda driven when not addressed");
   last_byte_a: assert property (@(posedge ref_clk) disable iff (reset)
      (state_ff == TWS_TX && fall && cnt_ff == `TWS_ACK_BIT && last_ff && !mack_ff && en
      && !start_det && !stop_det) |=> (stat_ff == `TWS_ST_TX_LAST && state_ff == TWS_IGNORE))
      else $error("last byte status wrong");
   read_dir_a: assert property (@(posedge ref_clk) disable iff (reset)
      (state_ff == TWS_ADDR && fall && cnt_ff == `TWS_ACK_BIT && en && !start_det && !stop_det)
      |=> (phase_ff == (sr_ff[0] ? TWS_PH_TX : TWS_PH_RX) && int_ff))
      else $error("direction not selected");
   start_free_a: assert property (@(posedge ref_clk) disable iff (reset)
      start_go |=> (!pend_ff && !start_go))
      else $error("queued start issued twice");
   wake_a: assert property (@(posedge ref_clk) disable iff (reset)
      (sleep_active && $rose(int_ff) && state_ff == TWS_WAIT) |-> wake_req)
      else $error("no wake request");

   tx_path_c: cover property (@(posedge ref_clk) stat_ff == `TWS_ST_TX_ACK && int_ff);
   gc_rx_c: cover property (@(posedge ref_clk) stat_ff == `TWS_ST_GC_ACK && int_ff);
   stop_c: cover property (@(posedge ref_clk) stat_ff == `TWS_ST_STOP && int_ff);
   queued_c: cover property (@(posedge ref_clk) start_go);
endmodule
`default_nettype wire

/* sim/tws_master_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Serial-side bus master: 80 ns bit period, 60 ns low and 20 ns high
module tws_master_model (
   input wire logic scl,
   input wire logic sda,
   output logic scl_oe,
   output logic sda_oe
);
   // Both lines released, so the pull-ups hold them high between frames
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end
   // A released SCL may be held low by the slave for a long time
   task automatic wait_high;
      int n;
      for (n = 0; n < 4000 && scl !== 1'b1; n++) #10;
   endtask
   task automatic bus_start;
      #40 sda_oe = 1'b1;
      #40 scl_oe = 1'b1;
   endtask
   task automatic bus_stop;
      #40 sda_oe = 1'b1;
      #20 scl_oe = 1'b0;
      wait_high();
      #40 sda_oe = 1'b0;
      #80;
   endtask
   // SDA moves 40 ns into the low phase, after the synced fall has landed
   // A 1 releases SDA, so the returned bits are what the wire carried
   task automatic xbyte(input logic [8:0] d, output logic [8:0] q);
      int i;
      for (i = 8; i >= 0; i--) begin
         #40 sda_oe = ~d[i];
         #20 scl_oe = 1'b0;
         wait_high();
         #10 q[i] = sda;
         #10 scl_oe = 1'b1;
      end
   endtask
endmodule
`default_nettype wire

/* sim/tws_slave_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tws_regs.svh"
module tws_slave_tb_top;
   logic ref_clk, reset, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, s_scl_oe, s_sda_oe, m_scl_oe, m_sda_oe;
   logic arb_lost, sleep_active, wake_req, start_go, scl, sda;
   logic [7:0] awaddr, araddr, td;
   logic [31:0] wdata, rdata, v;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rs;
   logic [8:0] q;
   int mismatches, compares, i, n, go_count;
   // Open-drain wires with pull-ups
   assign scl = ~(s_scl_oe | m_scl_oe);
   assign sda = ~(s_sda_oe | m_sda_oe);
   tws_slave u_tws_slave (
      .ref_clk(ref_clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .scl_i(scl), .scl_o(), .scl_oe(s_scl_oe), .sda_i(sda), .sda_o(), .sda_oe(s_sda_oe),
      .arb_lost(arb_lost), .sleep_active(sleep_active), .wake_req(wake_req),
      .start_go(start_go)
   );
   tws_master_model u_tws_master_model (
      .scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe)
   );
   // The queued start is a one-cycle pulse, so count it as it happens
   always @(posedge ref_clk) begin
      if (start_go === 1'b1) go_count++;
   end
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Sampling at the falling edge sees ready as the next rising edge will
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      logic sa, sw, sb;
      @(posedge ref_clk);
      if (w) begin
         awaddr <= a;
         wdata <= {24'h0, d};
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
      end else begin
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
      end
      for (n = 0; n < 50; n++) begin
         @(negedge ref_clk);
         sa = (awvalid & awready) | (arvalid & arready);
         sw = wvalid & wready;
         sb = w ? bvalid : rvalid;
         v = rdata;
         rs = w ? bresp : rresp;
         @(posedge ref_clk);
         if (sa) begin
            awvalid <= 1'b0;
            arvalid <= 1'b0;
         end
         if (sw) wvalid <= 1'b0;
         if (sb) begin
            bready <= 1'b0;
            rready <= 1'b0;
            break;
         end
      end
      chk("axi_answer", n < 50, 1);
   endtask
   task automatic r8(input logic [7:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk("rdata", v, {24'h0, e});
      chk("rresp", rs, 2'b00);
   endtask
   task automatic w8(input logic [7:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
      chk("bresp", rs, 2'b00);
   endtask
   // One nine-bit slot, then the status it leaves behind
   task automatic xb(input logic f, input logic [8:0] s, input logic [8:0] e,
                     input logic [7:0] st);
      if (f) u_tws_master_model.bus_start();
      u_tws_master_model.xbyte(s, q);
      chk("serial_bits", q, e);
      repeat (6) @(posedge ref_clk);
      r8(`TWS_OFF_STAT, st);
      chk("scl_held", s_scl_oe, !(st inside {8'hf8, 8'h88, 8'h98, 8'hc0, 8'hc8}));
   endtask
   task automatic sp(input logic [7:0] st);
      u_tws_master_model.bus_stop();
      r8(`TWS_OFF_STAT, st);
   endtask
   task automatic te(input string nm);
      $display("test %s done", nm);
   endtask
   // Whole run needs about 20 us; twenty-five times that means a hang
   initial begin
      #500000;
      mismatches++;
      final_report();
   end
   initial begin
      mismatches = 0;
      compares = 0;
      reset = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready, arb_lost, sleep_active} = 7'h0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hf;
      repeat (8) @(posedge ref_clk);
      reset <= 1'b0;
      r8(`TWS_OFF_ADDR, `TWS_RST_ADDR);
      r8(`TWS_OFF_CTRL, `TWS_RST_CTRL);
      r8(`TWS_OFF_STAT, `TWS_ST_NONE);
      r8(`TWS_OFF_DATA, `TWS_RST_DATA);
      acc(1'b0, 8'h14, 8'h00);
      chk("unmapped_rresp", rs, 2'b10);
      acc(1'b1, 8'h14, 8'h55);
      chk("unmapped_bresp", rs, 2'b10);
      w8(`TWS_OFF_ADDR, 8'ha5);
      r8(`TWS_OFF_ADDR, 8'ha5);
      w8(`TWS_OFF_CTRL, 8'h44);
      r8(`TWS_OFF_CTRL, 8'h44);
      te("registers");
      xb(1'b1, {8'ha4, 1'b1}, {8'ha4, 1'b0}, 8'h60);
      w8(`TWS_OFF_CTRL, 8'hc4);
      xb(1'b0, {8'h11, 1'b1}, {8'h11, 1'b0}, 8'h80);
      r8(`TWS_OFF_DATA, 8'h11);
      w8(`TWS_OFF_CTRL, 8'hc4);
      sp(8'ha0);
      w8(`TWS_OFF_CTRL, 8'hc4);
      xb(1'b1, {8'ha4, 1'b1}, {8'ha4, 1'b0}, 8'h60);
      w8(`TWS_OFF_CTRL, 8'h84);
      xb(1'b0, {8'h22, 1'b1}, {8'h22, 1'b1}, 8'h88);
      w8(`TWS_OFF_CTRL, 8'hc4);
      sp(8'hf8);
      te("receive");
      xb(1'b1, {8'h00, 1'b1}, {8'h00, 1'b0}, 8'h70);
      w8(`TWS_OFF_CTRL, 8'hc4);
      xb(1'b0, {8'h5a, 1'b1}, {8'h5a, 1'b0}, 8'h90);
      r8(`TWS_OFF_DATA, 8'h5a);
      w8(`TWS_OFF_CTRL, 8'h84);
      xb(1'b0, {8'h33, 1'b1}, {8'h33, 1'b1}, 8'h98);
      w8(`TWS_OFF_CTRL, 8'hc4);
      sp(8'hf8);
      w8(`TWS_OFF_ADDR, 8'ha4);
      xb(1'b1, {8'h00, 1'b1}, {8'h00, 1'b1}, 8'hf8);
      sp(8'hf8);
      te("general_call");
      w8(`TWS_OFF_CTRL, 8'h04);
      xb(1'b1, {8'ha4, 1'b1}, {8'ha4, 1'b1}, 8'hf8);
      sp(8'hf8);
      w8(`TWS_OFF_CTRL, 8'h44);
      xb(1'b1, {8'ha4, 1'b1}, {8'ha4, 1'b0}, 8'h60);
      w8(`TWS_OFF_CTRL, 8'hc4);
      sp(8'ha0);
      w8(`TWS_OFF_CTRL, 8'hc4);
      te("isolation");
      for (i = 0; i < 2; i++) begin
         td = i ? 8'hc3 : 8'h3c;
         if (i == 1) begin
            @(posedge ref_clk);
            arb_lost <= 1'b1;
            @(posedge ref_clk);
            arb_lost <= 1'b0;
         end
         xb(1'b1, {8'ha5, 1'b1}, {8'ha5, 1'b0}, i ? 8'hb0 : 8'ha8);
         w8(`TWS_OFF_DATA, td);
         w8(`TWS_OFF_CTRL, 8'h84);
         xb(1'b0, {8'hff, i[0]}, {td, i[0]}, i ? 8'hc0 : 8'hc8);
         w8(`TWS_OFF_CTRL, i ? 8'he4 : 8'hc4);
         if (i == 0) xb(1'b0, {8'hff, 1'b1}, {8'hff, 1'b1}, 8'hf8);
         else r8(`TWS_OFF_SLEEP, 8'h02);
         sp(8'hf8);
      end
      chk("start_go", go_count, 1);
      te("transmit");
      @(posedge ref_clk);
      sleep_active <= 1'b1;
      xb(1'b1, {8'ha4, 1'b1}, {8'ha4, 1'b0}, 8'h60);
      chk("wake_req", wake_req, 1);
      chk("scl_wake", s_scl_oe, 1);
      w8(`TWS_OFF_CTRL, 8'hc4);
      repeat (6) @(posedge ref_clk);
      chk("wake_done", wake_req, 0);
      chk("scl_free", s_scl_oe, 0);
      xb(1'b0, {8'h77, 1'b1}, {8'h77, 1'b0}, 8'h80);
      r8(`TWS_OFF_DATA, 8'hc3);
      @(posedge ref_clk);
      sleep_active <= 1'b0;
      w8(`TWS_OFF_CTRL, 8'hc4);
      sp(8'ha0);
      te("sleep");
      final_report();
   end
endmodule
`default_nettype wire
